/* lmsc_cfg.svh */
// constants for the led matrix scan and current configuration block
`ifndef LMSC_CFG_SVH
`define LMSC_CFG_SVH
// ---------------------------------------------------------------
// register byte offsets
// ---------------------------------------------------------------
`define LMSC_OFS_SCAN 12'h000
`define LMSC_OFS_GAIN 12'h004
`define LMSC_OFS_SCALE 12'h008
`define LMSC_OFS_STATUS 12'h00C
`define LMSC_OFS_SERIAL 12'h010
// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define LMSC_SCAN_SIZE_LSB 0
`define LMSC_SCAN_ORDER_REVERSE_BIT 4
`define LMSC_SCAN_POS_LSB 8
`define LMSC_SCAN_LINES_LSB 16
`define LMSC_SCALE_R_LSB 0
`define LMSC_SCALE_G_LSB 8
`define LMSC_SCALE_B_LSB 16
// ---------------------------------------------------------------
// reset values
// ---------------------------------------------------------------
`define LMSC_GAIN_RST 3'h3
`define LMSC_SCALE_RST 8'h7F
`define LMSC_SIZE_RST 3'h0
`define LMSC_LINES_RST 5'h10
// ---------------------------------------------------------------
// timing
// ---------------------------------------------------------------
`define LMSC_REF_MHZ 100
`define LMSC_LINE_NS 1000
`define LMSC_LINE_CYC ((`LMSC_LINE_NS * `LMSC_REF_MHZ) / 1000)
`define LMSC_SHIFT_MAX_MHZ 50
`endif

/* lmsc_pkg.sv */
// types for the led matrix scan and current configuration block
package lmsc_pkg;
	// matrix layout and scan order codes
	typedef enum logic [2:0] {
		LMSC_SZ_INDEP = 3'h0,
		LMSC_SZ_32 = 3'h1,
		LMSC_SZ_48_123 = 3'h2,
		LMSC_SZ_48_132 = 3'h3,
		LMSC_SZ_4864_123 = 3'h4,
		LMSC_SZ_4864_132 = 3'h5,
		LMSC_SZ_64_1234 = 3'h6,
		LMSC_SZ_64_ALT = 3'h7
	} lmsc_size_t;
	// scan sequencer states, gray along the usual path
	typedef enum logic [1:0] {
		LMSC_ST_IDLE = 2'b00,
		LMSC_ST_ON = 2'b01,
		LMSC_ST_WAIT = 2'b11
	} lmsc_state_t;
endpackage : lmsc_pkg

/* lmsc_serial_rx.sv */
// serial link receiver: samples shift clock, shifts data, echoes out
`timescale 1ns/10ps
module lmsc_serial_rx (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic i_sclk,
	input wire logic i_sdata,
	output logic o_sdata,
	output logic [31:0] o_word,
	output logic [5:0] o_bits
);
	// two-flop synchronisers for clock and data
	logic [1:0] sclk_sync_reg;
	logic [1:0] sdat_sync_reg;
	logic sclk_last_reg;
	logic rise;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sclk_sync_reg <= 2'h0;
			sdat_sync_reg <= 2'h0;
		end else begin
			sclk_sync_reg <= {sclk_sync_reg[0], i_sclk};
			sdat_sync_reg <= {sdat_sync_reg[0], i_sdata};
		end
	end
	// edge detector reads only the second stage
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			sclk_last_reg <= 1'b0;
		end else begin
			sclk_last_reg <= sclk_sync_reg[1];
		end
	end
	assign rise = sclk_sync_reg[1] & ~sclk_last_reg;
	// data moves on rising edge of the shift clock
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_word <= 32'h0000_0000;
			o_sdata <= 1'b0;
			o_bits <= 6'h00;
		end else if (rise) begin
			o_word <= {o_word[30:0], sdat_sync_reg[1]};
			o_sdata <= o_word[31];
			o_bits <= (o_bits == 6'h20) ? 6'h01 : o_bits + 6'h01;
		end
	end
endmodule : lmsc_serial_rx

/* lmsc_axil.sv */
// axi4-lite slave register file for the configuration block
`timescale 1ns/10ps
`include "lmsc_cfg.svh"
module lmsc_axil (
	input wire logic i_clk,
	input wire logic i_rst_n,
	input wire logic [11:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [11:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	input wire logic [31:0] i_status,
	input wire logic [31:0] i_serial,
	output logic [31:0] o_scan,
	output logic [2:0] o_gain,
	output logic [23:0] o_scale
);
	// ---------------------------------------------------------------
	// write path
	// ---------------------------------------------------------------
	logic aw_held_reg;
	logic w_held_reg;
	logic [11:0] aw_addr_reg;
	logic [31:0] w_data_reg;
	logic [3:0] w_strb_reg;
	logic do_write;
	// apply strobes lane by lane
	function automatic logic [31:0] merge(input logic [31:0] old,
		input logic [31:0] nw, input logic [3:0] st);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (st[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction : merge
	assign o_awready = !aw_held_reg && !o_bvalid;
	assign o_wready = !w_held_reg && !o_bvalid;
	assign do_write = aw_held_reg && w_held_reg && !o_bvalid;
	// address and data may arrive in either order
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			aw_held_reg <= 1'b0;
			w_held_reg <= 1'b0;
			aw_addr_reg <= 12'h000;
			w_data_reg <= 32'h0000_0000;
			w_strb_reg <= 4'h0;
		end else begin
			if (i_awvalid && o_awready) begin
				aw_held_reg <= 1'b1;
				aw_addr_reg <= i_awaddr;
			end else if (do_write) begin
				aw_held_reg <= 1'b0;
			end
			if (i_wvalid && o_wready) begin
				w_held_reg <= 1'b1;
				w_data_reg <= i_wdata;
				w_strb_reg <= i_wstrb;
			end else if (do_write) begin
				w_held_reg <= 1'b0;
			end
		end
	end
	// register storage and write response
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_scan <= {11'h000, `LMSC_LINES_RST, 16'h0000};
			o_gain <= `LMSC_GAIN_RST;
			o_scale <= {3{`LMSC_SCALE_RST}};
			o_bvalid <= 1'b0;
			o_bresp <= 2'h0;
		end else begin
			if (do_write) begin
				o_bvalid <= 1'b1;
				o_bresp <= 2'h0;
				case (aw_addr_reg[11:2])
				`LMSC_OFS_SCAN >> 2: begin
					o_scan <= merge(o_scan, w_data_reg, w_strb_reg);
				end
				`LMSC_OFS_GAIN >> 2: begin
					if (w_strb_reg[0]) begin
						o_gain <= w_data_reg[2:0];
					end
				end
				`LMSC_OFS_SCALE >> 2: begin
					// top lane has no storage, cut on purpose
					o_scale <= 24'(merge({8'h00, o_scale}, w_data_reg,
						w_strb_reg));
				end
				`LMSC_OFS_STATUS >> 2, `LMSC_OFS_SERIAL >> 2: begin
					o_bresp <= 2'h0;
				end
				default: begin
					o_bresp <= 2'h2; // unmapped: slave error
				end
				endcase
			end else if (i_bready) begin
				o_bvalid <= 1'b0;
			end
		end
	end
	// ---------------------------------------------------------------
	// read path
	// ---------------------------------------------------------------
	assign o_arready = !o_rvalid;
	always_ff @(posedge i_clk) begin
		if (!i_rst_n) begin
			o_rvalid <= 1'b0;
			o_rdata <= 32'h0000_0000;
			o_rresp <= 2'h0;
		end else if (i_arvalid && o_arready) begin
			o_rvalid <= 1'b1;
			o_rresp <= 2'h0;
			case (i_araddr[11:2])
			`LMSC_OFS_SCAN >> 2: o_rdata <= o_scan;
			`LMSC_OFS_GAIN >> 2: o_rdata <= {29'h0, o_gain};
			`LMSC_OFS_SCALE >> 2: o_rdata <= {8'h00, o_scale};
			`LMSC_OFS_STATUS >> 2: o_rdata <= i_status;
			`LMSC_OFS_SERIAL >> 2: o_rdata <= i_serial;
			default: begin
				o_rdata <= 32'h0000_0000;
				o_rresp <= 2'h2;
			end
			endcase
		end else if (i_rready) begin
			o_rvalid <= 1'b0;
		end
	end
endmodule : lmsc_axil

/* lmsc_top.sv */
// led matrix scan organisation and current setting, top level
// Contract
// - independent or stacked, up to four drivers
// - size code picks layout and scan order
// - independent: own section, own switches
// - stacked pair: lines 1-16, then 17-32
// - rotated driver reverses its switch order
// - 3-bit gain code, default 011b
// - per-colour 8-bit scale, (1+code)/256
// - colour scales reset to 0111 1111b
// - shift clock at most 50 MHz, rising edge
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
`include "lmsc_cfg.svh"
module lmsc_top #(
	parameter int unsigned LINE_CYCLES = `LMSC_LINE_CYC
) (
	input wire logic I_REF_CLK,
	input wire logic I_RESETN,
	input wire logic [11:0] I_AWADDR,
	input wire logic I_AWVALID,
	output logic O_AWREADY,
	input wire logic [31:0] I_WDATA,
	input wire logic [3:0] I_WSTRB,
	input wire logic I_WVALID,
	output logic O_WREADY,
	output logic [1:0] O_BRESP,
	output logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic [11:0] I_ARADDR,
	input wire logic I_ARVALID,
	output logic O_ARREADY,
	output logic [31:0] O_RDATA,
	output logic [1:0] O_RRESP,
	output logic O_RVALID,
	input wire logic I_RREADY,
	input wire logic I_SHIFT_CLK,
	input wire logic I_SERIAL_IN,
	output logic O_SERIAL_OUT,
	output logic [15:0] O_LINE_SWITCH,
	output logic O_SCAN_ACTIVE,
	output logic [1:0] O_ACTIVE_DRIVER,
	output logic [2:0] O_GLOBAL_GAIN_CODE,
	output logic [7:0] O_RED_GROUP_SCALE,
	output logic [7:0] O_GREEN_GROUP_SCALE,
	output logic [7:0] O_BLUE_GROUP_SCALE,
	output lmsc_pkg::lmsc_size_t O_MATRIX_SIZE_SELECT
);
	import lmsc_pkg::*;
	// elaboration check on the line dwell
	if (LINE_CYCLES < 1) begin : g_bad_line
		$error("line dwell must be at least one cycle");
	end
	// ---------------------------------------------------------------
	// register file and serial link
	// ---------------------------------------------------------------
	logic [31:0] scan_cfg; // size, reversal, position, line count
	logic [2:0] gain_cfg; // global gain code
	logic [23:0] scale_cfg; // three colour scales
	logic [31:0] status; // read-back of live state
	logic [31:0] serial_word; // last shifted word
	logic [5:0] serial_bits; // bits seen in the current word
	lmsc_axil u_regs (
		.i_clk(I_REF_CLK),
		.i_rst_n(I_RESETN),
		.i_awaddr(I_AWADDR),
		.i_awvalid(I_AWVALID),
		.o_awready(O_AWREADY),
		.i_wdata(I_WDATA),
		.i_wstrb(I_WSTRB),
		.i_wvalid(I_WVALID),
		.o_wready(O_WREADY),
		.o_bresp(O_BRESP),
		.o_bvalid(O_BVALID),
		.i_bready(I_BREADY),
		.i_araddr(I_ARADDR),
		.i_arvalid(I_ARVALID),
		.o_arready(O_ARREADY),
		.o_rdata(O_RDATA),
		.o_rresp(O_RRESP),
		.o_rvalid(O_RVALID),
		.i_rready(I_RREADY),
		.i_status(status),
		.i_serial(serial_word),
		.o_scan(scan_cfg),
		.o_gain(gain_cfg),
		.o_scale(scale_cfg)
	);
	// shift clock is sampled; at 100 MHz reference, 50 MHz is only
	// reliable when duty is held, so a faster link is the host's fault
	lmsc_serial_rx u_link (
		.i_clk(I_REF_CLK),
		.i_rst_n(I_RESETN),
		.i_sclk(I_SHIFT_CLK),
		.i_sdata(I_SERIAL_IN),
		.o_sdata(O_SERIAL_OUT),
		.o_word(serial_word),
		.o_bits(serial_bits)
	);
	// ---------------------------------------------------------------
	// current setting outputs
	// ---------------------------------------------------------------
	// gain code drives all 48 channels together; reset value 011b
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RESETN) begin
			O_GLOBAL_GAIN_CODE <= `LMSC_GAIN_RST;
		end else begin
			O_GLOBAL_GAIN_CODE <= gain_cfg;
		end
	end
	// colour scales; the analog side applies (1+code)/256
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RESETN) begin
			O_RED_GROUP_SCALE <= `LMSC_SCALE_RST;
			O_GREEN_GROUP_SCALE <= `LMSC_SCALE_RST;
			O_BLUE_GROUP_SCALE <= `LMSC_SCALE_RST;
		end else begin
			O_RED_GROUP_SCALE <= scale_cfg[`LMSC_SCALE_R_LSB +: 8];
			O_GREEN_GROUP_SCALE <= scale_cfg[`LMSC_SCALE_G_LSB +: 8];
			O_BLUE_GROUP_SCALE <= scale_cfg[`LMSC_SCALE_B_LSB +: 8];
		end
	end
	// ---------------------------------------------------------------
	// scan configuration, latched at frame boundary
	// ---------------------------------------------------------------
	lmsc_size_t size_reg; // active layout code
	logic rev_reg; // active switch reversal
	logic [1:0] pos_reg; // this driver's chain position
	logic [4:0] lines_reg; // used lines on this driver, 1..16
	logic frame_end; // last line of last driver finishes
	// new settings only take hold between frames
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RESETN) begin
			size_reg <= LMSC_SZ_INDEP;
			rev_reg <= 1'b0;
			pos_reg <= 2'h0;
			lines_reg <= `LMSC_LINES_RST;
		end else if (frame_end || !O_SCAN_ACTIVE) begin
			size_reg <= lmsc_size_t'(scan_cfg[`LMSC_SCAN_SIZE_LSB +: 3]);
			rev_reg <= scan_cfg[`LMSC_SCAN_ORDER_REVERSE_BIT];
			pos_reg <= scan_cfg[`LMSC_SCAN_POS_LSB +: 2];
			lines_reg <= (scan_cfg[`LMSC_SCAN_LINES_LSB +: 5] == 5'h00 ||
				scan_cfg[`LMSC_SCAN_LINES_LSB +: 5] > 5'h10) ?
				5'h10 : scan_cfg[`LMSC_SCAN_LINES_LSB +: 5];
		end
	end
	assign O_MATRIX_SIZE_SELECT = size_reg;
	// index of the last slot in the scan sequence, one less than the drivers taking part
	function automatic logic [1:0] last_idx(input lmsc_size_t s);
		case (s)
		LMSC_SZ_INDEP: last_idx = 2'h0; // each scans alone
		LMSC_SZ_32: last_idx = 2'h1;
		LMSC_SZ_48_123, LMSC_SZ_48_132,
		LMSC_SZ_4864_123, LMSC_SZ_4864_132: last_idx = 2'h2;
		LMSC_SZ_64_1234, LMSC_SZ_64_ALT: last_idx = 2'h3;
		default: last_idx = 2'h0;
		endcase
	endfunction : last_idx
	// chain driver that owns the n-th slot of the scan order
	function automatic logic [1:0] slot_drv(input lmsc_size_t s,
		input logic [1:0] n);
		case (s)
		LMSC_SZ_48_132, LMSC_SZ_4864_132: begin
			slot_drv = (n == 2'h1) ? 2'h2 : (n == 2'h2) ? 2'h1 : n;
		end
		LMSC_SZ_64_ALT: begin
			slot_drv = (n == 2'h0) ? 2'h0 : 2'h3 - (n - 2'h1);
		end
		default: slot_drv = n;
		endcase
	endfunction : slot_drv
	// ---------------------------------------------------------------
	// scan sequencer
	// ---------------------------------------------------------------
	lmsc_state_t state_reg;
	logic [1:0] slot_reg; // position in scan order
	logic [3:0] line_reg; // logical line on owning driver
	logic [31:0] dwell_reg; // cycles left on current line
	logic line_done;
	logic mine; // this driver owns the current slot
	assign line_done = (state_reg == LMSC_ST_ON) && (dwell_reg == 32'h0);
	assign frame_end = line_done && (line_reg == lines_reg[3:0] - 4'h1) &&
		(slot_reg == last_idx(size_reg));
	// in independent mode this driver always scans its own section
	assign mine = (size_reg == LMSC_SZ_INDEP) ||
		(slot_drv(size_reg, slot_reg) == pos_reg);
	// state, slot and line stepping
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RESETN) begin
			state_reg <= LMSC_ST_IDLE;
			slot_reg <= 2'h0;
			line_reg <= 4'h0;
			dwell_reg <= 32'h0;
		end else begin
			case (state_reg)
			LMSC_ST_IDLE: begin
				state_reg <= LMSC_ST_ON;
				dwell_reg <= LINE_CYCLES - 1;
			end
			LMSC_ST_ON: begin
				if (dwell_reg != 32'h0) begin
					dwell_reg <= dwell_reg - 32'h1;
				end else begin
					dwell_reg <= LINE_CYCLES - 1;
					// unused lines sit after the used ones
					if (line_reg == lines_reg[3:0] - 4'h1) begin
						line_reg <= 4'h0;
						slot_reg <= frame_end ? 2'h0 : slot_reg + 2'h1;
					end else begin
						line_reg <= line_reg + 4'h1;
					end
				end
			end
			default: state_reg <= LMSC_ST_IDLE;
			endcase
		end
	end
	// one-hot switch; reversal maps logical n to switch 15-n, so
	// spares land on 14/15 or on 1/0 as the rotation dictates
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RESETN) begin
			O_LINE_SWITCH <= 16'h0000;
		end else if (state_reg == LMSC_ST_ON && mine) begin
			O_LINE_SWITCH <= rev_reg ?
				(16'h8000 >> line_reg) : (16'h0001 << line_reg);
		end else begin
			O_LINE_SWITCH <= 16'h0000;
		end
	end
	// live state for read-back
	always_ff @(posedge I_REF_CLK) begin
		if (!I_RESETN) begin
			O_SCAN_ACTIVE <= 1'b0;
			O_ACTIVE_DRIVER <= 2'h0;
		end else begin
			O_SCAN_ACTIVE <= (state_reg == LMSC_ST_ON);
			O_ACTIVE_DRIVER <= slot_drv(size_reg, slot_reg);
		end
	end
	// fields fill 24 bits, topped up to 32 with eight zero bits
	assign status = {8'h00, serial_bits, O_ACTIVE_DRIVER, slot_reg,
		line_reg, rev_reg, size_reg, O_LINE_SWITCH[15:12], mine,
		O_SCAN_ACTIVE};
endmodule : lmsc_top

/* lmsc_monitor.sv */
// assertion checker for the led matrix configuration block
`timescale 1ns/10ps
module lmsc_monitor
	import lmsc_pkg::*;
(
	input wire logic I_REF_CLK,
	input wire logic I_RESETN,
	input wire logic I_AWVALID,
	input wire logic O_AWREADY,
	input wire logic I_WVALID,
	input wire logic O_WREADY,
	input wire logic O_BVALID,
	input wire logic I_BREADY,
	input wire logic I_ARVALID,
	input wire logic O_ARREADY,
	input wire logic [31:0] O_RDATA,
	input wire logic [1:0] O_RRESP,
	input wire logic O_RVALID,
	input wire logic I_RREADY,
	input wire logic [15:0] O_LINE_SWITCH,
	input wire logic O_SCAN_ACTIVE,
	input wire logic [2:0] O_GLOBAL_GAIN_CODE,
	input wire logic [7:0] O_RED_GROUP_SCALE,
	input wire logic [7:0] O_GREEN_GROUP_SCALE,
	input wire logic [7:0] O_BLUE_GROUP_SCALE,
	input wire lmsc_pkg::lmsc_size_t O_MATRIX_SIZE_SELECT
);
	// one clock domain, so one default clock and reset
	default clocking cb @(posedge I_REF_CLK);
	endclocking
	default disable iff (!I_RESETN);
	// ---------------------------------------------------------------
	// register bus handshakes
	// ---------------------------------------------------------------
	a_bvalid_held: assert property (O_BVALID && !I_BREADY |=> O_BVALID)
		else $error("write answer dropped before taken");
	a_rvalid_held: assert property (O_RVALID && !I_RREADY
		|=> O_RVALID && $stable(O_RDATA))
		else $error("read answer changed before taken");
	a_read_answer: assert property (I_ARVALID && O_ARREADY |=> O_RVALID)
		else $error("read answer not one cycle after address");
	a_write_answer: assert property (I_AWVALID && O_AWREADY && I_WVALID
		&& O_WREADY |-> ##[1:2] O_BVALID)
		else $error("write answer late");
	a_refused_zero: assert property (O_RVALID && O_RRESP == 2'h2
		|-> O_RDATA == 32'h0) else $error("refused read carries data");
	// ---------------------------------------------------------------
	// current codes and scan lines
	// ---------------------------------------------------------------
	a_reset_values: assert property ($rose(I_RESETN)
		|-> O_GLOBAL_GAIN_CODE == 3'h3 && O_RED_GROUP_SCALE == 8'h7F
		&& O_GREEN_GROUP_SCALE == 8'h7F && O_BLUE_GROUP_SCALE == 8'h7F
		&& O_MATRIX_SIZE_SELECT == LMSC_SZ_INDEP && O_LINE_SWITCH == 16'h0)
		else $error("outputs not at reset values");
	a_switch_onehot: assert property ($onehot0(O_LINE_SWITCH))
		else $error("more than one line switch on");
	a_switch_scan: assert property (O_LINE_SWITCH != 16'h0
		|-> O_SCAN_ACTIVE) else $error("line switch on outside scan");
	a_switch_dwell: assert property ($changed(O_LINE_SWITCH)
		&& O_LINE_SWITCH != 16'h0 |=> $stable(O_LINE_SWITCH))
		else $error("line switch glitch");
	// main scenarios reached
	c_write: cover property (O_BVALID && I_BREADY);
	c_refused: cover property (O_RVALID && O_RRESP == 2'h2);
	c_scan: cover property ($rose(O_SCAN_ACTIVE));
endmodule : lmsc_monitor
bind lmsc_top lmsc_monitor u_mon (.I_REF_CLK, .I_RESETN, .I_AWVALID,
	.O_AWREADY, .I_WVALID, .O_WREADY, .O_BVALID, .I_BREADY, .I_ARVALID,
	.O_ARREADY, .O_RDATA, .O_RRESP, .O_RVALID, .I_RREADY, .O_LINE_SWITCH,
	.O_SCAN_ACTIVE, .O_GLOBAL_GAIN_CODE, .O_RED_GROUP_SCALE,
	.O_GREEN_GROUP_SCALE, .O_BLUE_GROUP_SCALE, .O_MATRIX_SIZE_SELECT);

/* lmsc_host_model.sv */
// host model: drives the serial shift clock and data of one frame
`timescale 1ns/10ps
module lmsc_host_model #(
	parameter real HALF_NS = 62.5
) (
	input wire logic i_go,
	input wire logic [31:0] i_word,
	output logic o_sclk,
	output logic o_sdata,
	output logic o_busy
);
	// clock stands low between frames
	initial begin
		o_sclk = 1'b0;
		o_sdata = 1'b0;
		o_busy = 1'b0;
	end
	// msb first; data moves on the falling edge, far from the rising one
	always @(posedge i_go) begin
		o_busy = 1'b1;
		for (int i = 31; i >= 0; i--) begin
			o_sdata = i_word[i];
			#(HALF_NS);
			o_sclk = 1'b1;
			#(HALF_NS);
			o_sclk = 1'b0;
		end
		// released line shows the inverse, never the last bit
		o_sdata = ~i_word[0];
		o_busy = 1'b0;
	end
endmodule : lmsc_host_model

/* lmsc_top_test.sv */
// self-checking bench for the led matrix configuration block
`timescale 1ns/10ps
`include "lmsc_cfg.svh"
module lmsc_top_test;
	import lmsc_pkg::*;
	// ---------------------------------------------------------------
	// stimulus and observed signals
	// ---------------------------------------------------------------
	logic I_REF_CLK = 1'b0;
	logic I_RESETN = 1'b0;
	logic [11:0] I_AWADDR = 12'h0;
	logic I_AWVALID = 1'b0;
	logic [31:0] I_WDATA = 32'h0;
	logic [3:0] I_WSTRB = 4'h0;
	logic I_WVALID = 1'b0;
	logic I_BREADY = 1'b0;
	logic [11:0] I_ARADDR = 12'h0;
	logic I_ARVALID = 1'b0;
	logic I_RREADY = 1'b0;
	wire I_SHIFT_CLK;
	wire I_SERIAL_IN;
	logic O_AWREADY, O_WREADY, O_BVALID, O_ARREADY, O_RVALID;
	logic O_SERIAL_OUT, O_SCAN_ACTIVE;
	logic [1:0] O_BRESP, O_RRESP, O_ACTIVE_DRIVER;
	logic [31:0] O_RDATA;
	logic [15:0] O_LINE_SWITCH;
	logic [2:0] O_GLOBAL_GAIN_CODE;
	logic [7:0] O_RED_GROUP_SCALE, O_GREEN_GROUP_SCALE, O_BLUE_GROUP_SCALE;
	lmsc_size_t O_MATRIX_SIZE_SELECT;
	logic go = 1'b0;
	logic [31:0] word = 32'h0;
	wire busy;
	int fails = 0;
	int checks = 0;
	// expected live settings, tracked from what was written
	logic [2:0] e_size, e_gain;
	logic [23:0] e_scale;
	wire [29:0] cfg_now = {O_MATRIX_SIZE_SELECT, O_GLOBAL_GAIN_CODE,
		O_BLUE_GROUP_SCALE, O_GREEN_GROUP_SCALE, O_RED_GROUP_SCALE};
	// drivers in the chain per size code
	logic [3:0] drv_tab [8] = '{4'h1, 4'h3, 4'h7, 4'h7, 4'h7, 4'h7, 4'hF, 4'hF};
	always #5 I_REF_CLK = ~I_REF_CLK;
	// short line dwell keeps frames brief
	lmsc_top #(.LINE_CYCLES(4)) uut (.I_REF_CLK, .I_RESETN, .I_AWADDR,
		.I_AWVALID, .O_AWREADY, .I_WDATA, .I_WSTRB, .I_WVALID, .O_WREADY,
		.O_BRESP, .O_BVALID, .I_BREADY, .I_ARADDR, .I_ARVALID, .O_ARREADY,
		.O_RDATA, .O_RRESP, .O_RVALID, .I_RREADY, .I_SHIFT_CLK, .I_SERIAL_IN,
		.O_SERIAL_OUT, .O_LINE_SWITCH, .O_SCAN_ACTIVE, .O_ACTIVE_DRIVER,
		.O_GLOBAL_GAIN_CODE, .O_RED_GROUP_SCALE, .O_GREEN_GROUP_SCALE,
		.O_BLUE_GROUP_SCALE, .O_MATRIX_SIZE_SELECT);
	lmsc_host_model host (.i_go(go), .i_word(word), .o_sclk(I_SHIFT_CLK),
		.o_sdata(I_SERIAL_IN), .o_busy(busy));
	// ---------------------------------------------------------------
	// shared tasks
	// ---------------------------------------------------------------
	task automatic stop_test();
		if (fails == 0 && checks > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask : stop_test
	task automatic check(input string nm, input logic [31:0] seen,
		input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			fails++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	// write: address and data offered together, each dropped when taken
	task automatic axi_write(input logic [11:0] a, input logic [31:0] d,
		input logic [3:0] s, input logic [1:0] er);
		logic aw;
		logic w;
		aw = 1'b1;
		w = 1'b1;
		I_AWADDR <= a;
		I_WDATA <= d;
		I_WSTRB <= s;
		I_AWVALID <= 1'b1;
		I_WVALID <= 1'b1;
		I_BREADY <= 1'b1;
		for (int n = 0; n < 200; n++) begin
			@(posedge I_REF_CLK);
			if (!aw && !w && O_BVALID === 1'b1) begin
				// bready stays up, so back-to-back calls never toggle it
				check("bresp", {30'h0, O_BRESP}, {30'h0, er});
				return;
			end
			if (aw && O_AWREADY === 1'b1) begin
				aw = 1'b0;
				I_AWVALID <= 1'b0;
			end
			if (w && O_WREADY === 1'b1) begin
				w = 1'b0;
				I_WVALID <= 1'b0;
			end
		end
		fails++;
		stop_test();
	endtask : axi_write
	task automatic axi_read(input logic [11:0] a, input logic [31:0] ed,
		input logic [1:0] er);
		logic ar;
		ar = 1'b1;
		I_ARADDR <= a;
		I_ARVALID <= 1'b1;
		I_RREADY <= 1'b1;
		for (int n = 0; n < 200; n++) begin
			@(posedge I_REF_CLK);
			if (!ar && O_RVALID === 1'b1) begin
				check("rdata", O_RDATA, ed);
				check("rresp", {30'h0, O_RRESP}, {30'h0, er});
				return;
			end
			if (O_ARREADY === 1'b1) begin
				ar = 1'b0;
				I_ARVALID <= 1'b0;
			end
		end
		fails++;
		stop_test();
	endtask : axi_read
	// the size code lands only at a frame end, so wait a bounded while
	task automatic wait_cfg();
		for (int n = 0; n < 3000 && cfg_now !== {e_size, e_gain, e_scale};
			n++)
			@(posedge I_REF_CLK);
		check("config", {2'h0, cfg_now}, {2'h0, e_size, e_gain, e_scale});
		if (cfg_now !== {e_size, e_gain, e_scale})
			stop_test();
	endtask : wait_cfg
	// ---------------------------------------------------------------
	// scenarios
	// ---------------------------------------------------------------
	task automatic t_reset();
		e_size = 3'h0;
		e_gain = 3'h3;
		e_scale = 24'h7F7F7F;
		wait_cfg();
		axi_read(`LMSC_OFS_GAIN, 32'h3, 2'h0);
		axi_read(`LMSC_OFS_SCALE, 32'h007F7F7F, 2'h0);
		axi_read(`LMSC_OFS_SCAN, 32'h00100000, 2'h0);
	endtask : t_reset
	// every gain code, upper lanes ignored; ends on code 4
	task automatic t_gain();
		for (int c = 0; c < 9; c++) begin
			e_gain = (c == 8) ? 3'h4 : c[2:0];
			axi_write(`LMSC_OFS_GAIN, {24'hABCDEF, 5'h0, e_gain}, 4'h1, 2'h0);
			wait_cfg();
			axi_read(`LMSC_OFS_GAIN, {29'h0, e_gain}, 2'h0);
		end
	endtask : t_gain
	// red strongest at full code, then one lane alone
	task automatic t_scale();
		e_scale = 24'h3360FF;
		axi_write(`LMSC_OFS_SCALE, {8'h0, e_scale}, 4'hF, 2'h0);
		wait_cfg();
		e_scale = 24'h3311FF;
		axi_write(`LMSC_OFS_SCALE, 32'h5A5A115A, 4'h2, 2'h0);
		wait_cfg();
		axi_read(`LMSC_OFS_SCALE, {8'h0, e_scale}, 2'h0);
	endtask : t_scale
	// collect which switches and drivers take part in the scan
	task automatic t_scan(input logic [2:0] sz, input logic rev,
		input logic [1:0] pos, input logic [4:0] ln, input logic [15:0] esw,
		input logic [3:0] edrv);
		logic [15:0] sw;
		logic [3:0] drv;
		sw = 16'h0;
		drv = 4'h0;
		e_size = sz;
		axi_write(`LMSC_OFS_SCAN, {11'h0, ln, 6'h0, pos, 3'h0, rev, 1'b0, sz},
			4'hF, 2'h0);
		wait_cfg();
		repeat (2000) begin
			@(posedge I_REF_CLK);
			sw = sw | O_LINE_SWITCH;
			if (O_SCAN_ACTIVE === 1'b1)
				drv[O_ACTIVE_DRIVER] = 1'b1;
		end
		check("switches", {16'h0, sw}, {16'h0, esw});
		check("drivers", {28'h0, drv}, {28'h0, edrv});
	endtask : t_scan
	task automatic t_sizes();
		for (int s = 0; s < 8; s++)
			t_scan(s[2:0], 1'b0, 2'h0, 5'h10, 16'hFFFF, drv_tab[s]);
		t_scan(3'h0, 1'b0, 2'h0, 5'h0E, 16'h3FFF, 4'h1);
		t_scan(3'h1, 1'b1, 2'h1, 5'h0E, 16'hFFFC, 4'h3);
	endtask : t_sizes
	task automatic t_refuse();
		axi_read(12'h020, 32'h0, 2'h2);
		axi_write(12'h020, 32'hFFFFFFFF, 4'hF, 2'h2);
	endtask : t_refuse
	// one frame at 8 MHz, word read back over the register bus
	task automatic t_serial();
		word <= 32'hA5C30F96;
		go <= 1'b1;
		repeat (2) @(posedge I_REF_CLK);
		for (int n = 0; n < 1000 && busy === 1'b1; n++)
			@(posedge I_REF_CLK);
		if (busy === 1'b1) begin
			fails++;
			stop_test();
		end
		go <= 1'b0;
		repeat (6) @(posedge I_REF_CLK);
		// echo lags a full word, so it still shows the reset word's lsb
		check("serial out", {31'h0, O_SERIAL_OUT}, 32'h0);
		axi_read(`LMSC_OFS_SERIAL, 32'hA5C30F96, 2'h0);
	endtask : t_serial
	// ---------------------------------------------------------------
	// main sequence, with a second reset in mid-run
	// ---------------------------------------------------------------
	initial begin
		repeat (20) @(posedge I_REF_CLK);
		I_RESETN <= 1'b1;
		t_reset();
		t_gain();
		t_scale();
		t_sizes();
		t_refuse();
		t_serial();
		I_RESETN <= 1'b0;
		repeat (3) @(posedge I_REF_CLK);
		I_RESETN <= 1'b1;
		t_reset();
		stop_test();
	end
endmodule : lmsc_top_test
